// File: hdl/dsc_core.sv
// Purpose: DDR2 device command, bank and data burst core
// Assumes: CK is slow against CLK; pins held stable a few CLK around edges
// Notes: Storage keeps only the low column bits per bank, rows alias
module dsc_core
  import dsc_pkg::*;
#(
  parameter int COL_KEEP = 7
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CK,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [dsc_pkg::BANK_W-1:0] BA,
  input wire logic [dsc_pkg::ROW_W-1:0] ADDR,
  input wire logic [dsc_pkg::DQ_W-1:0] DQ_I,
  output logic [dsc_pkg::DQ_W-1:0] DQ_O,
  output logic DQ_OE,
  input wire logic LOW_BYTE_STROBE_I,
  output logic LOW_BYTE_STROBE_O,
  output logic LOW_BYTE_STROBE_OE,
  input wire logic HIGH_BYTE_STROBE_I,
  output logic HIGH_BYTE_STROBE_O,
  output logic HIGH_BYTE_STROBE_OE,
  input wire logic LOW_BYTE_WRITE_MASK,
  input wire logic HIGH_BYTE_WRITE_MASK,
  input wire logic [dsc_pkg::REG_AW-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA
);
  import dsc_pkg::*;

  localparam int LNK_W = 42;
  localparam int MEM_AW = BANK_W + COL_KEEP;

  // Storage index needs column bits above the three burst offset bits
  if (COL_KEEP < 4 || COL_KEEP > COL_W) begin : g_bad_keep
    $error("COL_KEEP must lie between 4 and 10");
  end


  logic [LNK_W-1:0] lnk_in, sync1_r, sync2_r;
  logic s_ck, s_cke, s_cs_n;
  logic [2:0] s_cmd;
  logic [BANK_W-1:0] s_ba;
  logic [ROW_W-1:0] s_addr;
  logic [DQ_W-1:0] s_dq;
  logic [LANES-1:0] s_strobe, s_mask, strobe_d_r;
  logic ck_d_r, clk_on_r, rise_ev, fall_ev, cmd_ev;
  logic [7:0] cfg_r;
  logic bl8, ilv;
  logic [3:0] bl_beats;
  logic [LAT_W-1:0] rd_lat, wr_lat;
  logic [NBANKS-1:0] open_r;
  logic [ROW_W-1:0] row_r [NBANKS];
  logic col_cmd, bank_ok, err_r, err_set;
  dsc_pend_type pend_r;
  logic [LAT_W-1:0] pend_cnt_r;
  logic [BANK_W-1:0] pend_bank_r;
  logic [COL_W-1:0] pend_col_r;
  logic pend_ap_r, rd_go, wr_go;
  logic rd_active_r, rd_ap_r, rd_close;
  logic [BANK_W-1:0] rd_bank_r;
  logic [COL_W-1:0] rd_col_r;
  logic [BEAT_W-1:0] rd_beat_r, rd_beat;
  logic [2:0] rd_ofs;
  logic [MEM_AW-1:0] rd_idx;
  logic wr_active_r, wr_ap_r, wr_close, wr_on;
  logic [BANK_W-1:0] wr_bank_r;
  logic [COL_W-1:0] wr_col_r;
  logic [LANES-1:0] lane_we, lane_full;
  logic [MEM_AW-1:0] lane_idx [LANES];
  logic [DQ_W-1:0] mem [2**MEM_AW];
  logic [REFCNT_W-1:0] refcnt_r;

  // Every link pin passes two flops before use
  assign lnk_in = {CK, CKE, CS_N, RAS_N, CAS_N, WE_N, BA, ADDR, DQ_I,
                   HIGH_BYTE_STROBE_I, LOW_BYTE_STROBE_I,
                   HIGH_BYTE_WRITE_MASK, LOW_BYTE_WRITE_MASK};
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= lnk_in;
      sync2_r <= sync1_r;
    end
  end
  assign {s_ck, s_cke, s_cs_n, s_cmd, s_ba, s_addr, s_dq, s_strobe, s_mask} = sync2_r;

  // CK edges; clock enable taken at each rise gates later edges
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ck_d_r <= 1'b0;
      clk_on_r <= 1'b1;
    end else begin
      ck_d_r <= s_ck;
      if (s_ck && !ck_d_r) begin
        clk_on_r <= s_cke;
      end
    end
  end
  assign rise_ev = s_ck && !ck_d_r && clk_on_r;
  assign fall_ev = !s_ck && ck_d_r && clk_on_r;
  assign cmd_ev = rise_ev && !s_cs_n;

  // Configuration fields
  assign bl8 = cfg_r[CFG_BL8_BIT];
  assign ilv = cfg_r[CFG_ILV_BIT];
  assign bl_beats = bl8 ? BL8_BEATS : BL4_BEATS;
  // posted delay adds to read latency
  assign rd_lat = LAT_W'(cfg_r[CFG_AL_LSB +: CFG_FLD_W]) + LAT_W'(cfg_r[CFG_CL_LSB +: CFG_FLD_W]);
  assign wr_lat = rd_lat - LAT_W'(1);

  // Register writes; out-of-range latencies keep the old field
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      cfg_r <= CFG_RESET;
    end else if (REG_WR && REG_ADDR == REG_CFG) begin
      cfg_r[CFG_BL8_BIT] <= REG_WDATA[CFG_BL8_BIT];
      cfg_r[CFG_ILV_BIT] <= REG_WDATA[CFG_ILV_BIT];
      if (REG_WDATA[CFG_AL_LSB +: CFG_FLD_W] <= AL_MAX) begin
        cfg_r[CFG_AL_LSB +: CFG_FLD_W] <= REG_WDATA[CFG_AL_LSB +: CFG_FLD_W];
      end
      if (REG_WDATA[CFG_CL_LSB +: CFG_FLD_W] >= CL_MIN) begin
        cfg_r[CFG_CL_LSB +: CFG_FLD_W] <= REG_WDATA[CFG_CL_LSB +: CFG_FLD_W];
      end
    end
  end

  // Column command legality
  assign col_cmd = cmd_ev && (s_cmd == CMD_RD || s_cmd == CMD_WR);
  assign bank_ok = open_r[s_ba] && pend_r == PEND_IDLE;
  assign err_set = col_cmd && !bank_ok;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      open_r <= '0;
      for (int b = 0; b < NBANKS; b++) begin
        row_r[b] <= '0;
      end
    end else begin
      if (cmd_ev && s_cmd == CMD_ACT && !open_r[s_ba]) begin
        open_r[s_ba] <= 1'b1;
        row_r[s_ba] <= s_addr;
      end
      if (cmd_ev && s_cmd == CMD_PRE) begin
        if (s_addr[AP_BIT]) begin
          open_r <= '0;
        end else begin
          open_r[s_ba] <= 1'b0;
        end
      end
      if (rd_close) begin
        open_r[rd_bank_r] <= 1'b0;
      end
      if (wr_close) begin
        open_r[wr_bank_r] <= 1'b0;
      end
    end
  end

  // Posted column command waits out its latency in CK rises
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pend_r <= PEND_IDLE;
      pend_cnt_r <= '0;
      pend_bank_r <= '0;
      pend_col_r <= '0;
      pend_ap_r <= 1'b0;
    end else begin
      case (pend_r)
        PEND_IDLE: begin
          if (col_cmd && bank_ok) begin
            pend_r <= (s_cmd == CMD_RD) ? PEND_READ : PEND_WRITE;
            pend_cnt_r <= (s_cmd == CMD_RD) ? rd_lat : wr_lat;
            pend_bank_r <= s_ba;
            pend_col_r <= s_addr[COL_W-1:0];
            pend_ap_r <= s_addr[AP_BIT];
          end
        end
        PEND_READ, PEND_WRITE: begin
          if (rise_ev) begin
            pend_cnt_r <= pend_cnt_r - LAT_W'(1);
            if (pend_cnt_r == LAT_W'(1)) begin
              pend_r <= PEND_IDLE;
            end
          end
        end
        default: pend_r <= PEND_IDLE;
      endcase
    end
  end
  assign rd_go = pend_r == PEND_READ && rise_ev && pend_cnt_r == LAT_W'(1);
  assign wr_go = pend_r == PEND_WRITE && rise_ev && pend_cnt_r == LAT_W'(1);

  assign rd_beat = rd_go ? '0 : rd_beat_r;
  dsc_burst_seq u_rd_seq (
    .start(rd_go ? pend_col_r[2:0] : rd_col_r[2:0]),
    .beat(rd_beat[2:0]),
    .bl8(bl8),
    .interleave(ilv),
    .ofs(rd_ofs)
  );
  assign rd_idx = {(rd_go ? pend_bank_r : rd_bank_r),
                   (rd_go ? pend_col_r[COL_KEEP-1:3] : rd_col_r[COL_KEEP-1:3]), rd_ofs};
  assign rd_close = rd_active_r && (rise_ev || fall_ev) && rd_beat_r == bl_beats && rd_ap_r;

  // read burst, one word per CK edge; frozen edges hold the outputs
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      rd_active_r <= 1'b0;
      rd_beat_r <= '0;
      rd_bank_r <= '0;
      rd_col_r <= '0;
      rd_ap_r <= 1'b0;
      DQ_O <= '0;
      DQ_OE <= 1'b0;
      LOW_BYTE_STROBE_O <= 1'b0;
      HIGH_BYTE_STROBE_O <= 1'b0;
      LOW_BYTE_STROBE_OE <= 1'b0;
      HIGH_BYTE_STROBE_OE <= 1'b0;
    end else if (rd_go || (rd_active_r && (rise_ev || fall_ev))) begin
      if (rd_go) begin
        rd_bank_r <= pend_bank_r;
        rd_col_r <= pend_col_r;
        rd_ap_r <= pend_ap_r;
      end
      if (!rd_go && rd_beat_r == bl_beats) begin
        rd_active_r <= 1'b0;
        DQ_OE <= 1'b0;
        LOW_BYTE_STROBE_OE <= 1'b0;
        HIGH_BYTE_STROBE_OE <= 1'b0;
        LOW_BYTE_STROBE_O <= 1'b0;
        HIGH_BYTE_STROBE_O <= 1'b0;
      end else begin
        rd_active_r <= 1'b1;
        rd_beat_r <= rd_beat + BEAT_W'(1);
        DQ_O <= mem[rd_idx];
        DQ_OE <= 1'b1;
        LOW_BYTE_STROBE_O <= rise_ev;
        HIGH_BYTE_STROBE_O <= rise_ev;
        LOW_BYTE_STROBE_OE <= 1'b1;
        HIGH_BYTE_STROBE_OE <= 1'b1;
      end
    end
  end

  // Write burst window, closed when both lanes took their beats
  assign wr_on = wr_go || wr_active_r;
  assign wr_close = wr_active_r && (&lane_full) && wr_ap_r;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      wr_active_r <= 1'b0;
      wr_bank_r <= '0;
      wr_col_r <= '0;
      wr_ap_r <= 1'b0;
    end else if (wr_go) begin
      wr_active_r <= 1'b1;
      wr_bank_r <= pend_bank_r;
      wr_col_r <= pend_col_r;
      wr_ap_r <= pend_ap_r;
    end else if (wr_active_r && (&lane_full)) begin
      wr_active_r <= 1'b0;
    end
  end

  // each byte lane on its own strobe
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [BEAT_W-1:0] cnt_r, cnt;
    logic edge_seen;
    logic [2:0] ofs;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0] col;

    assign cnt = wr_go ? '0 : cnt_r;
    assign bank = wr_go ? pend_bank_r : wr_bank_r;
    assign col = wr_go ? pend_col_r : wr_col_r;
    assign edge_seen = s_strobe[g] ^ strobe_d_r[g];
    assign lane_full[g] = cnt_r == bl_beats;
    assign lane_we[g] = wr_on && edge_seen && cnt != bl_beats && !s_mask[g];
    dsc_burst_seq u_wr_seq (
      .start(col[2:0]),
      .beat(cnt[2:0]),
      .bl8(bl8),
      .interleave(ilv),
      .ofs(ofs)
    );
    assign lane_idx[g] = {bank, col[COL_KEEP-1:3], ofs};

    always_ff @(posedge CLK) begin
      if (!RESETN) begin
        strobe_d_r[g] <= 1'b0;
        cnt_r <= '0;
      end else begin
        strobe_d_r[g] <= s_strobe[g];
        if (wr_on && edge_seen && cnt != bl_beats) begin
          cnt_r <= cnt + BEAT_W'(1);
        end else if (wr_go) begin
          cnt_r <= '0;
        end
      end
    end
  end

  // Storage, masked bytes left untouched
  always_ff @(posedge CLK) begin
    for (int g = 0; g < LANES; g++) begin
      if (lane_we[g]) begin
        mem[lane_idx[g]][g*LANE_W +: LANE_W] <= s_dq[g*LANE_W +: LANE_W];
      end
    end
  end

  // Sticky access error, a new error beats the clear
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      err_r <= 1'b0;
    end else begin
      err_r <= err_set || (err_r &&
               !(REG_WR && REG_ADDR == REG_STATUS && REG_WDATA[STS_ERR_BIT]));
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      refcnt_r <= '0;
    end else if (cmd_ev && s_cmd == CMD_REF) begin
      refcnt_r <= refcnt_r + REFCNT_W'(1);
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      REG_RDATA <= '0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        REG_CFG: REG_RDATA <= 32'(cfg_r);
        REG_STATUS: REG_RDATA <= 32'({!clk_on_r, wr_active_r, rd_active_r, err_r, open_r});
        REG_REFCNT: REG_RDATA <= 32'(refcnt_r);
        default: REG_RDATA <= '0;
      endcase
    end else begin
      REG_RDATA <= '0;
    end
  end
endmodule

// File: hdl/dsc_pkg.sv
// Purpose: Shared constants for the DDR2 command core
// Assumes: Link pins are sampled by the core clock through two flops
// Notes: Command codes are the {row strobe, column strobe, write} levels
package dsc_pkg;
  // Pin group widths
  localparam int BANK_W = 3;
  localparam int NBANKS = 8;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int DQ_W = 16;
  localparam int LANE_W = 8;
  localparam int LANES = 2;
  localparam int AP_BIT = 10;
  localparam int BEAT_W = 4;
  localparam int LAT_W = 4;
  // Burst lengths in beats
  localparam logic [3:0] BL4_BEATS = 4'h4;
  localparam logic [3:0] BL8_BEATS = 4'h8;
  // Command codes, chip select low
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  // Register port map, byte offsets
  localparam int REG_AW = 4;
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_REFCNT = 4'h8;
  // Configuration fields
  localparam int CFG_BL8_BIT = 0;
  localparam int CFG_ILV_BIT = 1;
  localparam int CFG_AL_LSB = 2;
  localparam int CFG_CL_LSB = 5;
  localparam int CFG_FLD_W = 3;
  localparam logic [7:0] CFG_RESET = 8'ha0;
  localparam logic [2:0] AL_MAX = 3'h6;
  localparam logic [2:0] CL_MIN = 3'h2;
  // Status fields
  localparam int STS_ERR_BIT = 8;
  localparam int STS_RD_BIT = 9;
  localparam int STS_WR_BIT = 10;
  localparam int STS_FRZ_BIT = 11;
  localparam int REFCNT_W = 16;
  // Pending column command
  typedef enum logic [1:0] {PEND_IDLE, PEND_READ, PEND_WRITE} dsc_pend_type;
endpackage

// File: hdl/dsc_burst_seq.sv
// Purpose: Burst column offset for one beat
// Assumes: Beat index below the burst length
// Notes: Upper start bit kept as is for four-beat bursts
module dsc_burst_seq (
  input wire logic [2:0] start,
  input wire logic [2:0] beat,
  input wire logic bl8,
  input wire logic interleave,
  output logic [2:0] ofs
);
  logic [2:0] raw;

  // Wrap within the burst, sequential adds, interleaved toggles
  always_comb begin
    raw = interleave ? (start ^ beat) : 3'(start + beat);
    ofs = bl8 ? raw : {start[2], raw[1:0]};
  end
endmodule

// File: testbench/dsc_core_sva.sv
// Purpose: Port checks on the command core
// Assumes: Link clock of 20 core cycles
// Notes: Bound to every core instance
module dsc_core_chk (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CK,
  input wire logic [dsc_pkg::DQ_W-1:0] DQ_O,
  input wire logic DQ_OE,
  input wire logic LOW_BYTE_STROBE_O,
  input wire logic LOW_BYTE_STROBE_OE,
  input wire logic HIGH_BYTE_STROBE_O,
  input wire logic HIGH_BYTE_STROBE_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  import dsc_pkg::*;
  // One domain, so checks stay quiet in reset
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_low_oe_tie:
    assert property (LOW_BYTE_STROBE_OE == DQ_OE) else $error("low strobe enable");
  a_high_oe_tie:
    assert property (HIGH_BYTE_STROBE_OE == DQ_OE) else $error("high strobe enable");
  a_lanes_agree:
    assert property (DQ_OE |-> LOW_BYTE_STROBE_O == HIGH_BYTE_STROBE_O) else $error("lanes");
  a_launch_on_rise:
    assert property ($rose(DQ_OE) |-> CK && LOW_BYTE_STROBE_O) else $error("launch edge");
  a_fall_beat_low:
    assert property (DQ_OE && $fell(LOW_BYTE_STROBE_O) |-> !CK) else $error("fall beat");
  a_beat_holds:
    assert property ($rose(DQ_OE) |=> ($stable(DQ_O) && DQ_OE) [*8]) else $error("beat");
  a_strobe_turns:
    assert property ($rose(DQ_OE) |-> LOW_BYTE_STROBE_O [*8] ##[1:4] !LOW_BYTE_STROBE_O)
      else $error("strobe");
  a_burst_ends:
    assert property ($rose(DQ_OE) |-> DQ_OE [*8] ##[20:300] !DQ_OE) else $error("burst end");
  // Main read paths reached
  c_read: cover property ($rose(DQ_OE));
  c_fall_beat: cover property (DQ_OE && $fell(LOW_BYTE_STROBE_O));
  c_done: cover property ($fell(DQ_OE));
endmodule
bind dsc_core dsc_core_chk u_chk (
  .CLK(CLK), .RESETN(RESETN), .CK(CK), .DQ_O(DQ_O), .DQ_OE(DQ_OE),
  .LOW_BYTE_STROBE_O(LOW_BYTE_STROBE_O), .LOW_BYTE_STROBE_OE(LOW_BYTE_STROBE_OE),
  .HIGH_BYTE_STROBE_O(HIGH_BYTE_STROBE_O), .HIGH_BYTE_STROBE_OE(HIGH_BYTE_STROBE_OE)
);

// File: testbench/dsc_ctl_model.sv
// Purpose: Memory controller stand-in on the link pins
// Assumes: Tasks entered right after a core clock edge
// Notes: Link clock of 20 core cycles, runs only inside ticks
module dsc_ctl_model (
  input wire logic CLK,
  input wire logic [dsc_pkg::DQ_W-1:0] DQ_O,
  input wire logic DQ_OE,
  input wire logic LOW_BYTE_STROBE_O,
  output logic CK,
  output logic CS_N,
  output logic RAS_N,
  output logic CAS_N,
  output logic WE_N,
  output logic [dsc_pkg::BANK_W-1:0] BA,
  output logic [dsc_pkg::ROW_W-1:0] ADDR,
  output logic [dsc_pkg::DQ_W-1:0] DQ_I,
  output logic LOW_BYTE_STROBE_I,
  output logic HIGH_BYTE_STROBE_I
);
  timeunit 1ns;
  timeprecision 1ns;
  import dsc_pkg::*;
  logic [DQ_W-1:0] wq[$];
  logic [DQ_W-1:0] rdq[$];
  int wcnt = -1;
  int rises = 0;
  int first_rise = 0;
  bit wr_on = 0;
  logic oe_q = 0;
  logic st_q = 0;
  // Idle link: deselected, strobes low
  initial begin
    {CK, RAS_N, CAS_N, WE_N, BA, ADDR, DQ_I} = '0;
    CS_N = 1'b1;
    {LOW_BYTE_STROBE_I, HIGH_BYTE_STROBE_I} = 2'b00;
  end
  // each new strobe level marks one read word
  always @(posedge CLK) begin
    if (DQ_OE && (!oe_q || LOW_BYTE_STROBE_O != st_q)) rdq.push_back(DQ_O);
    if (DQ_OE && !oe_q) first_rise = rises;
    oe_q <= DQ_OE;
    st_q <= LOW_BYTE_STROBE_O;
  end
  // half link cycle; data moves 2 cycles early, strobe 3 late
  task automatic half(input logic v);
    logic beat;
    repeat (3) @(posedge CLK);
    if (v && wcnt > 0) wcnt--;
    if (v && wcnt == 0) begin
      wr_on = 1;
      wcnt = -1;
    end
    beat = wr_on && wq.size() > 0;
    if (beat) DQ_I <= wq.pop_front();
    repeat (2) @(posedge CLK);
    CK <= v;
    if (v) rises++;
    repeat (3) @(posedge CLK);
    if (beat) begin
      LOW_BYTE_STROBE_I <= ~LOW_BYTE_STROBE_I;
      HIGH_BYTE_STROBE_I <= ~HIGH_BYTE_STROBE_I;
    end else if (wr_on) begin
      wr_on = 0;
      DQ_I <= ~DQ_I;
    end
    repeat (2) @(posedge CLK);
  endtask
  // pins held 5 cycles before and 15 after the rise
  task automatic tick(input logic cs_n, input logic [2:0] c, input logic [BANK_W-1:0] b,
                      input logic [ROW_W-1:0] a);
    CS_N <= cs_n;
    {RAS_N, CAS_N, WE_N} <= c;
    BA <= b;
    ADDR <= a;
    half(1'b1);
    half(1'b0);
  endtask
  // Deselected cycles invert the address so stale values never match
  task automatic idle(input int n);
    repeat (n) tick(1'b1, 3'h7, ~BA, ~ADDR);
  endtask
endmodule

// File: testbench/dsc_core_test.sv
// Purpose: Self-checking bench for the command core
// Assumes: Controller model paces the link clock
// Notes: Clock enable and low write mask driven by tests, high mask unused
module dsc_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  import dsc_pkg::*;
  logic CLK = 0;
  logic RESETN = 0;
  logic [REG_AW-1:0] REG_ADDR = '0;
  logic [31:0] REG_WDATA = '0;
  logic REG_WR = 0;
  logic REG_RD = 0;
  logic CKE = 1'b1;
  logic LWM = 1'b0;
  logic [31:0] REG_RDATA;
  logic CK, CS_N, RAS_N, CAS_N, WE_N, DQ_OE, LSI, HSI, LSO, HSO;
  logic [BANK_W-1:0] BA;
  logic [ROW_W-1:0] ADDR;
  logic [DQ_W-1:0] DQ_I, DQ_O;
  int err_count = 0;
  int samples_checked = 0;
  // Core clock, 8 ns
  always #4 CLK = ~CLK;
  dsc_ctl_model m (.CLK(CLK), .DQ_O(DQ_O), .DQ_OE(DQ_OE), .LOW_BYTE_STROBE_O(LSO), .CK(CK),
    .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .ADDR(ADDR),
    .DQ_I(DQ_I), .LOW_BYTE_STROBE_I(LSI), .HIGH_BYTE_STROBE_I(HSI));
  dsc_core #(.COL_KEEP(7)) DUT (.CLK(CLK), .RESETN(RESETN), .CK(CK), .CKE(CKE),
    .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .ADDR(ADDR),
    .DQ_I(DQ_I), .DQ_O(DQ_O), .DQ_OE(DQ_OE), .LOW_BYTE_STROBE_I(LSI),
    .LOW_BYTE_STROBE_O(LSO), .LOW_BYTE_STROBE_OE(), .HIGH_BYTE_STROBE_I(HSI),
    .HIGH_BYTE_STROBE_O(HSO), .HIGH_BYTE_STROBE_OE(), .LOW_BYTE_WRITE_MASK(LWM),
    .HIGH_BYTE_WRITE_MASK(1'b0), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Register write, strobe dropped a full cycle before any reuse
  task automatic rwr(input logic [REG_AW-1:0] a, input logic [31:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
    @(posedge CLK);
  endtask
  // Register read, data sampled in the one cycle it stands
  task automatic rchk(input logic [REG_AW-1:0] a, input logic [31:0] e);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(posedge CLK);
    check(REG_RDATA, e);
  endtask
  task automatic wr_burst(input logic [2:0] b, input logic [12:0] a, input int wl,
                          input logic [15:0] base, input int n);
    for (int i = 0; i < n; i++) m.wq.push_back(base + 16'(i));
    m.wcnt = wl + 1;
    m.tick(1'b0, CMD_WR, b, a);
    m.idle(wl + n / 2 + 2);
  endtask
  task automatic rd_burst(input logic [2:0] b, input logic [12:0] a, input int rl,
                          input int n, input logic [127:0] e);
    int c;
    c = m.rises;
    m.rdq.delete();
    m.tick(1'b0, CMD_RD, b, a);
    m.idle(rl + n / 2 + 2);
    check(32'(m.first_rise - c - 1), 32'(rl));
    check(32'(m.rdq.size()), 32'(n));
    for (int i = 0; i < n; i++) check(32'(m.rdq[i]), 32'(e[127 - 16 * i -: 16]));
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge CLK);
    err_count++;
    complete_run;
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    rchk(REG_CFG, 32'h0000_00a0);
    rwr(REG_CFG, 32'h0000_00bc);
    rchk(REG_CFG, 32'h0000_00a0);
    rchk(4'hc, 32'h0000_0000);
    $display("register test done");
    m.tick(1'b0, CMD_ACT, 3'h1, 13'h0123);
    m.tick(1'b0, CMD_ACT, 3'h5, 13'h0456);
    rchk(REG_STATUS, 32'h0000_0022);
    wr_burst(3'h1, 13'h0000, 4, 16'h1000, 4);
    rd_burst(3'h1, 13'h0001, 5, 4, {64'h1001_1002_1003_1000, 64'h0});
    m.rdq.delete();
    m.tick(1'b1, CMD_RD, 3'h1, 13'h0001);
    m.idle(8);
    check(32'(m.rdq.size()), 32'h0000_0000);
    $display("sequential test done");
    rwr(REG_CFG, 32'h0000_00aa);
    rd_burst(3'h1, 13'h0401, 7, 4, {64'h1001_1000_1003_1002, 64'h0});
    rchk(REG_STATUS, 32'h0000_0020);
    m.tick(1'b0, CMD_RD, 3'h1, 13'h0001);
    m.idle(9);
    rchk(REG_STATUS, 32'h0000_0120);
    rwr(REG_STATUS, 32'h0000_0100);
    rchk(REG_STATUS, 32'h0000_0020);
    $display("precharge test done");
    rwr(REG_CFG, 32'h0000_00ab);
    wr_burst(3'h5, 13'h0000, 6, 16'h2000, 8);
    rd_burst(3'h5, 13'h0003, 7, 8, 128'h2003_2002_2001_2000_2007_2006_2005_2004);
    $display("long burst test done");
    // Low lane masked: high bytes new, low bytes keep the long burst data
    rwr(REG_CFG, 32'h0000_00a0);
    LWM <= 1'b1;
    wr_burst(3'h5, 13'h0000, 4, 16'h3010, 4);
    LWM <= 1'b0;
    rd_burst(3'h5, 13'h0000, 5, 4, {64'h3000_3001_3002_3003, 64'h0});
    $display("mask test done");
    m.tick(1'b0, CMD_PRE, 3'h0, 13'h0400);
    rchk(REG_STATUS, 32'h0000_0000);
    // Suspend, then the waking refresh must be ignored
    CKE <= 1'b0;
    m.idle(1);
    rchk(REG_STATUS, 32'h0000_0800);
    CKE <= 1'b1;
    m.tick(1'b0, CMD_REF, 3'h0, 13'h0000);
    rchk(REG_STATUS, 32'h0000_0000);
    m.tick(1'b0, CMD_REF, 3'h0, 13'h0000);
    m.tick(1'b0, CMD_REF, 3'h0, 13'h0000);
    rwr(REG_REFCNT, 32'h0000_ffff);
    rchk(REG_REFCNT, 32'h0000_0002);
    $display("refresh test done");
    complete_run;
  end
endmodule
